// >>> hw/psu_fault_restart_control.sv
// Purpose: fault response and restart control of the 12 V main output
// Assumes: fault and limit pins come from analog comparators
// Notes:   all long waits count ticks, not clocks
module psu_fault_restart_control #(
   parameter int unsigned TICK_CYCLES = psu_pkg::TICK_CYC
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        remote_on_a,
   input  wire logic        ov_a,
   input  wire logic        oc_a,
   input  wire logic        ot_a,
   input  wire logic        lim_a,
   input  wire logic        vhi_a,
   input  wire logic        margin_a,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata_q,
   output logic             out_en_q,
   output logic             led_q,
   output logic             cc_hold_q,
   output logic             hiccup_q,
   output logic             margin_q
);

   logic [6:0] pins_a;
   logic [6:0] pins_s;
   logic       tick;
   logic       pin_on;
   logic       ov_s;
   logic       oc_s;
   logic       ot_s;
   logic       lim_s;
   logic       vhi_s;
   logic       margin_s;

   assign pins_a   = {margin_a, vhi_a, lim_a, ot_a, oc_a, ov_a, remote_on_a};
   assign pin_on   = pins_s[0];
   assign ov_s     = pins_s[1];
   assign oc_s     = pins_s[2];
   assign ot_s     = pins_s[3];
   assign lim_s    = pins_s[4];
   assign vhi_s    = pins_s[5];
   assign margin_s = pins_s[6];

   pin_sync #(
      .W (7)
   ) u_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin_a   (pins_a),
      .lvl_q   (pins_s)
   );

   tick_gen #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .tick_q  (tick)
   );

   // Register file
   logic        op_on_q;
   logic        op_on_d;
   logic [1:0]  fcfg_q;
   logic [1:0]  fcfg_d;
   logic        mreg_q;
   logic        mreg_d;
   logic        fwm_q;
   logic        fwm_d;
   logic [31:0] rdata_d;
   logic        wr_oper;
   logic        wr_fcfg;
   logic        wr_marg;
   logic        wr_alrm;
   logic        wr_sts2;

   // Sequencer state
   psu_pkg::st_e st_q;
   psu_pkg::st_e st_d;
   logic [9:0]   tmr_q;
   logic [9:0]   tmr_d;
   logic [9:0]   win_q;
   logic [9:0]   win_d;
   logic [1:0]   ovc_q;
   logic [1:0]   ovc_d;
   logic [1:0]   lc_q;
   logic [1:0]   lc_d;
   logic         pend_q;
   logic         pend_d;
   logic [3:0]   alm_q;
   logic [3:0]   alm_d;
   logic [3:0]   set_a;
   logic         rsok_q;
   logic         rsok_d;
   logic         ok;
   logic         go_ov;
   logic         go_oc;
   logic         go_ot;
   logic         go_lim;
   logic         on_want;
   logic         cfg_rs;
   logic         blink_q;
   logic         blink_d;
   logic         ph_q;
   logic         ph_d;
   logic         out_en_d;
   logic         led_d;
   logic         cc_hold_d;
   logic         hiccup_d;
   logic         margin_d;

   assign wr_oper = wr && (addr == psu_pkg::A_OPER);
   assign wr_fcfg = wr && (addr == psu_pkg::A_FCFG);
   assign wr_marg = wr && (addr == psu_pkg::A_MARG);
   assign wr_alrm = wr && (addr == psu_pkg::A_ALRM);
   assign wr_sts2 = wr && (addr == psu_pkg::A_STS2);

   // Either source may switch the output off
   assign on_want = pin_on && op_on_q;

   // Only the latched cause may be released by reconfiguration
   assign cfg_rs = wr_fcfg && (st_q == psu_pkg::S_LATCH)
                   && ((lc_q[0] && !wdata[psu_pkg::FCFG_OC])
                   || (lc_q[1] && !wdata[psu_pkg::FCFG_OT]));

   always_comb
   begin
      op_on_d  = wr_oper ? wdata[psu_pkg::OPER_ON] : op_on_q;
      fcfg_d   = wr_fcfg ? wdata[1:0] : fcfg_q;
      mreg_d   = wr_marg ? wdata[psu_pkg::MARG_HI] : mreg_q;
      fwm_d    = fwm_q || wr_marg;
      margin_d = fwm_q ? mreg_q : margin_s;
      rdata_d  = 32'h0;
      if (rd)
      begin
         case (addr)
            psu_pkg::A_OPER: rdata_d = {31'h0, op_on_q};
            psu_pkg::A_FCFG: rdata_d = {30'h0, fcfg_q};
            psu_pkg::A_MARG: rdata_d = {30'h0, fwm_q, mreg_q};
            psu_pkg::A_STAT: rdata_d = {20'h0, ovc_q, lc_q, hiccup_q,
                                        cc_hold_q, led_q, st_q};
            psu_pkg::A_ALRM: rdata_d = {28'h0, alm_q};
            psu_pkg::A_STS2: rdata_d = {31'h0, rsok_q};
            default:         rdata_d = 32'h0;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         op_on_q  <= psu_pkg::OPER_RST;
         fcfg_q   <= psu_pkg::FCFG_RST;
         mreg_q   <= psu_pkg::MARG_RST;
         fwm_q    <= 1'h0;
         margin_q <= 1'h0;
         rdata_q  <= 32'h0;
      end
      else
      begin
         op_on_q  <= op_on_d;
         fcfg_q   <= fcfg_d;
         mreg_q   <= mreg_d;
         fwm_q    <= fwm_d;
         margin_q <= margin_d;
         rdata_q  <= rdata_d;
      end
   end

   always_comb
   begin
      st_d   = st_q;
      ovc_d  = ovc_q;
      win_d  = win_q;
      lc_d   = lc_q;
      pend_d = pend_q;
      set_a  = 4'h0;
      ok     = 1'h0;
      go_ov  = 1'h0;
      go_oc  = 1'h0;
      go_ot  = 1'h0;
      go_lim = 1'h0;
      tmr_d  = tick ? tmr_q + 10'h1 : tmr_q;

      // Quiet window forgets earlier overvoltage shutdowns
      if (ovc_q != 2'h0 && tick)
      begin
         if (win_q == psu_pkg::WINDOW_T - 10'h1)
         begin
            win_d = 10'h0;
            ovc_d = 2'h0;
         end
         else
         begin
            win_d = win_q + 10'h1;
         end
      end

      case (st_q)
         psu_pkg::S_OFF:
         begin
            if (on_want)
               st_d = psu_pkg::S_START;
         end
         psu_pkg::S_START:
         begin
            // Overload ignored here so paralleled units can come up
            if (!on_want)
               st_d = psu_pkg::S_OFF;
            else if (ov_s)
               go_ov = 1'h1;
            else if (ot_s)
               go_ot = 1'h1;
            else if (!lim_s)
            begin
               st_d = psu_pkg::S_ON;
               ok   = pend_q;
            end
            else if (tmr_q >= psu_pkg::GRACE_T)
            begin
               set_a[psu_pkg::ALM_SU] = 1'h1;
               go_oc = 1'h1;
            end
         end
         psu_pkg::S_ON:
         begin
            if (!on_want)
               st_d = psu_pkg::S_OFF;
            else if (ov_s)
               go_ov = 1'h1;
            else if (ot_s)
               go_ot = 1'h1;
            else if (oc_s)
               go_oc = 1'h1;
            else if (lim_s && !vhi_s)
            begin
               go_lim = !fcfg_q[psu_pkg::FCFG_OC];
               go_oc  = fcfg_q[psu_pkg::FCFG_OC];
            end
         end
         psu_pkg::S_WAIT:
         begin
            if (!on_want)
               st_d = psu_pkg::S_OFF;
            else if (tmr_q >= psu_pkg::RETRY_T && !ot_s)
               st_d = psu_pkg::S_START;
         end
         psu_pkg::S_LATCH:
         begin
            if (cfg_rs)
               st_d = psu_pkg::S_START;
            else if (!on_want)
               st_d = psu_pkg::S_OFF;
         end
         default:
         begin
            st_d = psu_pkg::S_OFF;
         end
      endcase

      if (go_ov)
      begin
         set_a[psu_pkg::ALM_OV] = 1'h1;
         pend_d = 1'h1;
         lc_d   = 2'h0;
         if (ovc_q == psu_pkg::OV_MAX)
            st_d = psu_pkg::S_LATCH;
         else
         begin
            st_d  = psu_pkg::S_WAIT;
            ovc_d = ovc_q + 2'h1;
            if (ovc_q == 2'h0)
               win_d = 10'h0;
         end
      end
      else if (go_ot)
      begin
         set_a[psu_pkg::ALM_OT] = 1'h1;
         pend_d = 1'h1;
         lc_d   = fcfg_q[psu_pkg::FCFG_OT] ? 2'h2 : 2'h0;
         st_d   = fcfg_q[psu_pkg::FCFG_OT] ? psu_pkg::S_LATCH : psu_pkg::S_WAIT;
      end
      else if (go_oc || go_lim)
      begin
         set_a[psu_pkg::ALM_OC] = 1'h1;
         pend_d = 1'h1;
         lc_d   = fcfg_q[psu_pkg::FCFG_OC] ? 2'h1 : 2'h0;
         st_d   = fcfg_q[psu_pkg::FCFG_OC] ? psu_pkg::S_LATCH : psu_pkg::S_WAIT;
      end

      if (ok)
         pend_d = 1'h0;
      if (st_d != st_q)
         tmr_d = 10'h0;

      // New events win over a clear in the same cycle
      if (ok)
         alm_d = set_a;
      else
         alm_d = (alm_q & ~(wr_alrm ? wdata[3:0] : 4'h0)) | set_a;
      rsok_d = ok || (rsok_q && !(wr_sts2 && wdata[psu_pkg::STS2_OK]));

      out_en_d  = (st_d == psu_pkg::S_START) || (st_d == psu_pkg::S_ON);
      cc_hold_d = (st_d == psu_pkg::S_START) && lim_s;
      blink_d   = (st_d == psu_pkg::S_ON) && lim_s && vhi_s;
      ph_d      = tick ? !ph_q : ph_q;
      led_d     = out_en_d && !(blink_d && ph_q);
      hiccup_d  = (st_d == psu_pkg::S_WAIT) && (go_lim || hiccup_q);
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         st_q      <= psu_pkg::S_OFF;
         tmr_q     <= 10'h0;
         win_q     <= 10'h0;
         ovc_q     <= 2'h0;
         lc_q      <= 2'h0;
         pend_q    <= 1'h0;
         alm_q     <= 4'h0;
         rsok_q    <= 1'h0;
         blink_q   <= 1'h0;
         ph_q      <= 1'h0;
         out_en_q  <= 1'h0;
         led_q     <= 1'h0;
         cc_hold_q <= 1'h0;
         hiccup_q  <= 1'h0;
      end
      else
      begin
         st_q      <= st_d;
         tmr_q     <= tmr_d;
         win_q     <= win_d;
         ovc_q     <= ovc_d;
         lc_q      <= lc_d;
         pend_q    <= pend_d;
         alm_q     <= alm_d;
         rsok_q    <= rsok_d;
         blink_q   <= blink_d;
         ph_q      <= ph_d;
         out_en_q  <= out_en_d;
         led_q     <= led_d;
         cc_hold_q <= cc_hold_d;
         hiccup_q  <= hiccup_d;
      end
   end

   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_ov_last;
      (st_q == psu_pkg::S_ON) && on_want && ov_s && (ovc_q == psu_pkg::OV_MAX);
   endsequence

   sequence s_latched;
      (st_q == psu_pkg::S_LATCH) && !out_en_q;
   endsequence

   sequence s_waiting;
      (st_q == psu_pkg::S_WAIT) && (tmr_q < psu_pkg::RETRY_T);
   endsequence

   a_pin_ignored: assert property (fwm_q && !wr_marg |=> margin_q == $past(mreg_q))
      else $error("margin followed the pin after firmware took over");

   a_grace_hold: assert property ((st_q == psu_pkg::S_START) && on_want && lim_s && !ov_s && !ot_s
                                  && (tmr_q < psu_pkg::GRACE_T) |=> out_en_q && cc_hold_q)
      else $error("startup overload tripped inside the grace time");

   a_grace_bound: assert property ((st_q == psu_pkg::S_START) |-> tmr_q <= psu_pkg::GRACE_T)
      else $error("startup overload held past the grace time");

   // The LED follows the phase one cycle late, so the toggle shows on the next edge
   a_led_blink: assert property (blink_q && $changed(ph_q) |=> !blink_q || (led_q != $past(led_q)))
      else $error("LED not blinking while limiting");

   a_hiccup_low: assert property ((st_q == psu_pkg::S_ON) && on_want && !ov_s && !ot_s && !oc_s && lim_s
                                  && !vhi_s && !fcfg_q[psu_pkg::FCFG_OC] |=> hiccup_q && !out_en_q)
      else $error("low voltage limiting did not hiccup");

   a_led_off: assert property (!out_en_q |-> !led_q)
      else $error("LED lit while the unit is off");

   a_led_on: assert property (out_en_q && !blink_q |-> led_q)
      else $error("LED dark while the unit is on");

   a_retry_wait: assert property (s_waiting |=> st_q != psu_pkg::S_START)
      else $error("overvoltage retry came too early");

   a_ov_latch: assert property (s_ov_last |=> s_latched)
      else $error("final overvoltage did not latch off");

   a_win_clear: assert property (tick && (ovc_q != 2'h0) && (win_q == psu_pkg::WINDOW_T - 10'h1)
                                 && !(out_en_q && ov_s) |=> ovc_q == 2'h0)
      else $error("quiet window did not clear the count");

   a_latch_stay: assert property ((st_q == psu_pkg::S_LATCH) && !out_en_q && on_want && !cfg_rs
                                  |=> s_latched)
      else $error("latched unit left latch without a restart action");

   a_cfg_restart: assert property (cfg_rs |=> (st_q == psu_pkg::S_START) ##1 out_en_q || !on_want)
      else $error("reconfiguration did not restart");

   a_restart_ok: assert property (ok && (set_a == 4'h0) |=> rsok_q && (alm_q == 4'h0))
      else $error("successful restart left alarms or no flag");

   a_off_req: assert property (!on_want |=> !out_en_q ##1 !out_en_q || on_want)
      else $error("off request did not remove the output");

endmodule : psu_fault_restart_control

// >>> hw/psu_pkg.sv
// Purpose: shared constants for the supply fault and restart controller
// Assumes: ref_clk at 10 MHz, seconds timed by a 100 ms internal tick
// Notes:   register offsets are byte addresses on the plain register port
// Contract
// - Pin rules until firmware writes, then ignored
// - Startup overload held constant current 20 s
// - Overload past grace applies configured protection
// - LED blinks while limiting above 10 V
// - Limiting below 10 V in restart mode hiccups
// - LED on when unit on, else off
// - Overcurrent and overtemp default to auto restart
// - Overvoltage: three retries, 1 s apart, 1 min
// - Three failed retries in window latch off
// - Fewer shutdowns in window clear count, restart
// - Fault settings may latch overcurrent or overtemp
// - Pin off then on restarts latched unit
// - Operation off then on restarts latched unit
// - Fault setting back to restart restarts unit
// - Successful restart clears alarms, sets restart flag
// - Pin or firmware off turns main output off
package psu_pkg;

   localparam int unsigned CLK_HZ   = 32'h0098_9680;
   localparam int unsigned MS_PER_S = 32'h0000_03e8;
   localparam int unsigned TICK_MS  = 32'h0000_0064;
   localparam int unsigned TICK_CYC = CLK_HZ / MS_PER_S * TICK_MS;

   localparam int unsigned GRACE_S  = 32'h0000_0014;
   localparam int unsigned RETRY_S  = 32'h0000_0001;
   localparam int unsigned WINDOW_S = 32'h0000_003c;

   localparam logic [9:0] GRACE_T  = 10'(GRACE_S * MS_PER_S / TICK_MS);
   localparam logic [9:0] RETRY_T  = 10'(RETRY_S * MS_PER_S / TICK_MS);
   localparam logic [9:0] WINDOW_T = 10'(WINDOW_S * MS_PER_S / TICK_MS);
   localparam logic [1:0] OV_MAX   = 2'h3;

   localparam logic [7:0] A_OPER = 8'h00;
   localparam logic [7:0] A_FCFG = 8'h04;
   localparam logic [7:0] A_MARG = 8'h08;
   localparam logic [7:0] A_STAT = 8'h0c;
   localparam logic [7:0] A_ALRM = 8'h10;
   localparam logic [7:0] A_STS2 = 8'h14;

   localparam int unsigned OPER_ON = 0;
   localparam int unsigned FCFG_OC = 0;
   localparam int unsigned FCFG_OT = 1;
   localparam int unsigned MARG_HI = 0;
   localparam int unsigned ALM_OV  = 0;
   localparam int unsigned ALM_OC  = 1;
   localparam int unsigned ALM_OT  = 2;
   localparam int unsigned ALM_SU  = 3;
   localparam int unsigned STS2_OK = 0;

   localparam logic       OPER_RST = 1'h1;
   localparam logic [1:0] FCFG_RST = 2'h0;
   localparam logic       MARG_RST = 1'h0;

   typedef enum logic [4:0] {
      S_OFF   = 5'h01,
      S_START = 5'h02,
      S_ON    = 5'h04,
      S_WAIT  = 5'h08,
      S_LATCH = 5'h10
   } st_e;

endpackage : psu_pkg

// >>> hw/pin_sync.sv
// Purpose: three-stage synchroniser for asynchronous pins
// Assumes: pins are slow levels
// Notes:   a change is taken once stages two and three agree
module pin_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] pin_a,
   output logic      [W-1:0] lvl_q
);

   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         logic [2:0] sh_q;
         logic [2:0] sh_d;
         logic       lv_d;

         always_comb
         begin
            sh_d = {sh_q[1:0], pin_a[i]};
            lv_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q[i];
         end

         always_ff @(posedge ref_clk)
         begin
            if (!rst_n)
            begin
               sh_q     <= 3'h0;
               lvl_q[i] <= 1'h0;
            end
            else
            begin
               sh_q     <= sh_d;
               lvl_q[i] <= lv_d;
            end
         end
      end
   endgenerate

endmodule : pin_sync

// >>> hw/tick_gen.sv
// Purpose: free-running timebase for second-scale timers
// Assumes: CYCLES fits in 20 bits
// Notes:   one-cycle pulse every CYCLES clocks
module tick_gen #(
   parameter int unsigned CYCLES = 32'h0000_0004
) (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   output logic      tick_q
);

   logic [19:0] cnt_q;
   logic [19:0] cnt_d;
   logic        tick_d;

   always_comb
   begin
      cnt_d  = cnt_q + 20'h1;
      tick_d = 1'h0;
      if (cnt_q == 20'(CYCLES - 1))
      begin
         cnt_d  = 20'h0;
         tick_d = 1'h1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         cnt_q  <= 20'h0;
         tick_q <= 1'h0;
      end
      else
      begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

endmodule : tick_gen

// >>> verification/power_stage_model.sv
// Purpose: power stage and fault comparators facing the controller
// Assumes: the bench raises fault requests as slow levels
// Notes:   overvoltage, overcurrent and high-voltage signals vanish while the output is disabled
module power_stage_model
(
   input  wire logic ref_clk,
   input  wire logic out_en,
   input  wire logic ov_req,
   input  wire logic oc_req,
   input  wire logic ot_req,
   input  wire logic lim_req,
   input  wire logic vhi_req,
   output logic      ov_a,
   output logic      oc_a,
   output logic      ot_a,
   output logic      lim_a,
   output logic      vhi_a
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      {ov_a, oc_a, ot_a, lim_a, vhi_a} = 5'h00;
   end

   always @(posedge ref_clk)
   begin
      ov_a  <= ov_req & out_en;
      oc_a  <= oc_req & out_en;
      lim_a <= lim_req; // Load demand is there before the output comes up
      vhi_a <= vhi_req & out_en;
      ot_a  <= ot_req; // Heat outlasts a disabled output
   end
endmodule : power_stage_model

// >>> verification/psu_fault_restart_control_tb_top.sv
// Purpose: self-checking bench of the fault and restart controller
// Assumes: TICK_CYCLES of 4, so 1 s is 40 clocks
// Notes:   off-then-on gaps before latched restarts kept at 2 s by the bench itself
module psu_fault_restart_control_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic        ref_clk     = 1'b0;
   logic        rst_n       = 1'b0;
   logic        remote_on_a = 1'b0;
   logic        margin_a    = 1'b0;
   logic [7:0]  addr        = 8'h00;
   logic [31:0] wdata       = 32'h0;
   logic        wr          = 1'b0;
   logic        rd          = 1'b0;
   logic        ov_req      = 1'b0;
   logic        oc_req      = 1'b0;
   logic        ot_req      = 1'b0;
   logic        lim_req     = 1'b0;
   logic        vhi_req     = 1'b0;
   logic        ov_a, oc_a, ot_a, lim_a, vhi_a;
   logic [31:0] rdata_q;
   logic        out_en_q, led_q, cc_hold_q, hiccup_q, margin_q;
   logic [31:0] v;
   int          n_mismatch  = 0;
   int          n_tests     = 0;
   int          tg;

   always #50 ref_clk = ~ref_clk;

   psu_fault_restart_control #(.TICK_CYCLES(4)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
      .remote_on_a(remote_on_a), .ov_a(ov_a), .oc_a(oc_a), .ot_a(ot_a), .lim_a(lim_a),
      .vhi_a(vhi_a), .margin_a(margin_a), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata_q(rdata_q), .out_en_q(out_en_q), .led_q(led_q), .cc_hold_q(cc_hold_q),
      .hiccup_q(hiccup_q), .margin_q(margin_q));

   power_stage_model stage (.ref_clk(ref_clk), .out_en(out_en_q), .ov_req(ov_req),
      .oc_req(oc_req), .ot_req(ot_req), .lim_req(lim_req), .vhi_req(vhi_req),
      .ov_a(ov_a), .oc_a(oc_a), .ot_a(ot_a), .lim_a(lim_a), .vhi_a(vhi_a));

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge ref_clk);
      wr    <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd   <= 1'b0;
      #1 d = rdata_q;
   endtask : rd_reg

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
      logic [31:0] d;
      rd_reg(a, d);
      chk(d, exp, msg);
   endtask : rd_chk

   // Bounded poll; a state never reached fails the compare
   task automatic poll_st(input logic [4:0] st, input int n);
      logic [31:0] d;
      d = 32'h0;
      for (int i = 0; i < n; i++)
      begin
         rd_reg(psu_pkg::A_STAT, d);
         if (d[4:0] === st)
            break;
      end
      chk({27'h0, d[4:0]}, {27'h0, st}, "state");
   endtask : poll_st

   task automatic pin_cycle;
      remote_on_a <= 1'b0;
      cyc(80);
      remote_on_a <= 1'b1;
   endtask : pin_cycle

   initial
   begin
      #2_000_000;
      n_mismatch++;
      give_verdict();
   end

   initial
   begin
      cyc(8);
      chk({30'h0, out_en_q, led_q}, 32'h0, "outputs in reset");
      cyc(8);
      rst_n <= 1'b1;
      rd_chk(psu_pkg::A_OPER, 32'h1, "oper reset");
      rd_chk(psu_pkg::A_FCFG, 32'h0, "fault cfg reset");
      rd_chk(psu_pkg::A_MARG, 32'h0, "margin reset");
      rd_chk(psu_pkg::A_ALRM, 32'h0, "alarm reset");
      rd_chk(8'h20, 32'h0, "unmapped read");
      poll_st(5'h01, 4);
      $display("test reset done");

      lim_req     <= 1'b1;
      vhi_req     <= 1'b1;
      remote_on_a <= 1'b1;
      cyc(20);
      chk({30'h0, cc_hold_q, out_en_q}, 32'h3, "startup hold");
      cyc(700);
      chk({30'h0, cc_hold_q, out_en_q}, 32'h3, "hold within grace");
      poll_st(5'h08, 80);
      rd_chk(psu_pkg::A_ALRM, 32'h0a, "startup timeout alarm");
      lim_req <= 1'b0;
      poll_st(5'h04, 40);
      rd_chk(psu_pkg::A_STS2, 32'h1, "restart flag");
      rd_chk(psu_pkg::A_ALRM, 32'h0, "alarms cleared");
      wr_reg(psu_pkg::A_STS2, 32'h1);
      rd_chk(psu_pkg::A_STS2, 32'h0, "restart flag cleared");
      $display("test startup done");

      margin_a <= 1'b1;
      cyc(8);
      chk({31'h0, margin_q}, 32'h1, "pin margin");
      wr_reg(psu_pkg::A_MARG, 32'h0);
      cyc(8);
      chk({31'h0, margin_q}, 32'h0, "pin ignored");
      rd_chk(psu_pkg::A_MARG, 32'h2, "firmware owns margin");
      margin_a <= 1'b0;
      wr_reg(psu_pkg::A_MARG, 32'h1);
      cyc(8);
      chk({31'h0, margin_q}, 32'h1, "firmware margin");
      $display("test margin done");

      chk({30'h0, out_en_q, led_q}, 32'h3, "led lit when on");
      lim_req <= 1'b1;
      cyc(8);
      tg = 0;
      for (int i = 0; i < 24; i++)
      begin
         @(posedge ref_clk);
         #1 if (led_q !== v[0])
            tg++;
         v[0] = led_q;
      end
      chk({31'h0, tg >= 4}, 32'h1, "led blinks");
      chk({31'h0, out_en_q}, 32'h1, "stays on while limiting");
      vhi_req <= 1'b0;
      cyc(10);
      chk({30'h0, hiccup_q, out_en_q}, 32'h2, "hiccup");
      lim_req <= 1'b0;
      vhi_req <= 1'b1;
      poll_st(5'h04, 60);
      $display("test limiting done");

      oc_req <= 1'b1;
      poll_st(5'h08, 10);
      rd_chk(psu_pkg::A_ALRM, 32'h2, "oc alarm");
      oc_req <= 1'b0;
      poll_st(5'h04, 40);
      rd_chk(psu_pkg::A_ALRM, 32'h0, "alarms cleared");
      $display("test oc restart done");

      ov_req <= 1'b1;
      poll_st(5'h08, 10);
      ov_req <= 1'b0;
      poll_st(5'h04, 40);
      rd_reg(psu_pkg::A_STAT, v);
      chk({30'h0, v[11:10]}, 32'h1, "one ov counted");
      cyc(2500);
      rd_reg(psu_pkg::A_STAT, v);
      chk({30'h0, v[11:10]}, 32'h0, "window clears count");
      $display("test ov window done");

      ov_req <= 1'b1;
      poll_st(5'h10, 200);
      rd_reg(psu_pkg::A_STAT, v);
      chk({20'h0, v[11:8]}, 32'hc, "three retries, ov cause");
      chk({30'h0, out_en_q, led_q}, 32'h0, "latched dark");
      rd_chk(psu_pkg::A_ALRM, 32'h1, "ov alarm");
      ov_req <= 1'b0;
      cyc(400);
      poll_st(5'h10, 2);
      pin_cycle();
      poll_st(5'h04, 40);
      rd_chk(psu_pkg::A_STS2, 32'h1, "restart flag");
      wr_reg(psu_pkg::A_STS2, 32'h1);
      $display("test ov latch done");

      wr_reg(psu_pkg::A_FCFG, 32'h1);
      oc_req <= 1'b1;
      poll_st(5'h10, 10);
      rd_reg(psu_pkg::A_STAT, v);
      chk({30'h0, v[9:8]}, 32'h1, "oc cause");
      oc_req <= 1'b0;
      wr_reg(psu_pkg::A_FCFG, 32'h0);
      poll_st(5'h04, 8);
      $display("test oc latch done");

      wr_reg(psu_pkg::A_FCFG, 32'h2);
      ot_req <= 1'b1;
      poll_st(5'h10, 10);
      ot_req <= 1'b0;
      cyc(8);
      poll_st(5'h10, 2);
      wr_reg(psu_pkg::A_OPER, 32'h0);
      cyc(80);
      wr_reg(psu_pkg::A_OPER, 32'h1);
      poll_st(5'h04, 40);
      $display("test ot latch done");

      wr_reg(psu_pkg::A_OPER, 32'h0);
      cyc(3);
      chk({30'h0, out_en_q, led_q}, 32'h0, "firmware off");
      wr_reg(psu_pkg::A_OPER, 32'h1);
      poll_st(5'h04, 40);
      remote_on_a <= 1'b0;
      cyc(8);
      chk({30'h0, out_en_q, led_q}, 32'h0, "pin off");
      $display("test off requests done");
      give_verdict();
   end
endmodule : psu_fault_restart_control_tb_top
